// ==== rtl/rvs_regs.sv ====
// Rail voltage select register bank with sleep level selection
// Behaviour at a glance
// Bus strobes are taken on the edge where they are high; a read
// answers one cycle later and its data holds until the next read.
// A read and a write on one edge return the old contents.
// Unmapped writes vanish and unmapped reads answer zero, so a
// host probing the map never waits for an answer that never comes.
// Sleep pins are asynchronous and cost five edges to reach the
// outputs; enable and pin select changes cost one edge.
// Only the default set chosen by PART_VARIANT is ever loaded, so
// one netlist serves one part variant.
// The pin filter trades two edges of latency for immunity to
// single stage glitches on the board level sleep lines.
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Sleep pin filter, one per pin
// ************************************************************
// Three flops and an agreement test; a glitch that lives in one
// stage only never reaches the sleep decision
module rvs_pin_filter #(
	parameter logic [2:0] SYNC_RST = 3'h7
) (
	input  wire logic i_clock,
	input  wire logic i_rst,
	input  wire logic i_pin,
	output logic      o_level
);

	logic [2:0] sync_q;
	logic [2:0] sync_d;
	logic       level_q;
	logic       level_d;

	// Level only moves once stages two and three agree
	always_comb begin
		sync_d  = {sync_q[1:0], i_pin};
		level_d = level_q;
		if (sync_q[1] == sync_q[2]) begin
			level_d = sync_q[2];
		end
	end

	// Reset to the idle high level, so no false sleep entry
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			sync_q  <= SYNC_RST;
			level_q <= SYNC_RST[2];
		end else begin
			sync_q  <= sync_d;
			level_q <= level_d;
		end
	end

	assign o_level = level_q; // Costs one edge of latency

endmodule : rvs_pin_filter

// ************************************************************
// Register bank
// ************************************************************
module rvs_regs #(
	parameter int PART_VARIANT = 0
) (
	input  wire logic                           i_clock,
	input  wire logic                           i_rst,
	input  wire rvs_pkg::rvs_req_t              i_req,
	input  wire logic [rvs_pkg::NUM_PINS-1:0]   i_sleep_pin_n,
	input  wire logic [rvs_pkg::NUM_RAILS-1:0]  i_sleep_en,
	input  wire logic [rvs_pkg::NUM_RAILS-1:0]  i_sleep_pin_sel,
	output logic [7:0]                          o_rdata,
	output logic                                o_rvalid,
	output rvs_pkg::rvs_levels_t                o_levels,
	output logic [rvs_pkg::NUM_RAILS-1:0]       o_in_sleep
);

	// ************************************************************
	// Register storage
	// ************************************************************
	logic [7:0] rail5_sleep_level_q;
	logic [7:0] rail5_sleep_level_d;
	logic [7:0] rail6_normal_level_q;
	logic [7:0] rail6_normal_level_d;
	logic [7:0] rail6_sleep_level_q;
	logic [7:0] rail6_sleep_level_d;
	logic [7:0] aux_ldo2_levels_q;
	logic [7:0] aux_ldo2_levels_d;
	logic [7:0] aux_ldo3_levels_q;
	logic [7:0] aux_ldo3_levels_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       rvalid_q;
	logic       rvalid_d;

	// ************************************************************
	// Write decode
	// ************************************************************
	// Write decode; reserved bit 0 of converter sleep regs masked off
	always_comb begin
		rail5_sleep_level_d  = rail5_sleep_level_q;
		rail6_normal_level_d = rail6_normal_level_q;
		rail6_sleep_level_d  = rail6_sleep_level_q;
		aux_ldo2_levels_d    = aux_ldo2_levels_q;
		aux_ldo3_levels_d    = aux_ldo3_levels_q;
		if (i_req.wr) begin
			unique case (i_req.addr)
				rvs_pkg::RAIL5_SLEEP_OFS: begin
					rail5_sleep_level_d = i_req.wdata
						& rvs_pkg::CONV_SLEEP_WMASK;
				end
				rvs_pkg::RAIL6_NORMAL_OFS: begin
					rail6_normal_level_d = i_req.wdata;
				end
				rvs_pkg::RAIL6_SLEEP_OFS: begin
					rail6_sleep_level_d = i_req.wdata
						& rvs_pkg::CONV_SLEEP_WMASK;
				end
				rvs_pkg::AUX2_LEVELS_OFS: begin
					aux_ldo2_levels_d = i_req.wdata;
				end
				rvs_pkg::AUX3_LEVELS_OFS: begin
					aux_ldo3_levels_d = i_req.wdata;
				end
				default: begin
					// Unmapped writes are dropped
				end
			endcase
		end
	end

	// ************************************************************
	// Read decode
	// ************************************************************
	// Read decode; answer one cycle after the request
	always_comb begin
		rvalid_d = i_req.rd;
		rdata_d  = rdata_q;
		if (i_req.rd) begin
			unique case (i_req.addr)
				rvs_pkg::RAIL5_SLEEP_OFS: begin
					rdata_d = rail5_sleep_level_q;
				end
				rvs_pkg::RAIL6_NORMAL_OFS: begin
					rdata_d = rail6_normal_level_q;
				end
				rvs_pkg::RAIL6_SLEEP_OFS: begin
					rdata_d = rail6_sleep_level_q;
				end
				rvs_pkg::AUX2_LEVELS_OFS: begin
					rdata_d = aux_ldo2_levels_q;
				end
				rvs_pkg::AUX3_LEVELS_OFS: begin
					rdata_d = aux_ldo3_levels_q;
				end
				default: begin
					rdata_d = rvs_pkg::UNMAPPED_READ;
				end
			endcase
		end
	end

	// ************************************************************
	// Storage flops
	// ************************************************************
	// Defaults come from the variant table, not one fixed constant
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			rail5_sleep_level_q  <=
				rvs_pkg::RAIL5_SLEEP_RST[PART_VARIANT];
			rail6_normal_level_q <=
				rvs_pkg::RAIL6_NORMAL_RST[PART_VARIANT];
			rail6_sleep_level_q  <=
				rvs_pkg::RAIL6_SLEEP_RST[PART_VARIANT];
			aux_ldo2_levels_q    <=
				rvs_pkg::AUX2_LEVELS_RST[PART_VARIANT];
			aux_ldo3_levels_q    <=
				rvs_pkg::AUX3_LEVELS_RST[PART_VARIANT];
		end else begin
			rail5_sleep_level_q  <= rail5_sleep_level_d;
			rail6_normal_level_q <= rail6_normal_level_d;
			rail6_sleep_level_q  <= rail6_sleep_level_d;
			aux_ldo2_levels_q    <= aux_ldo2_levels_d;
			aux_ldo3_levels_q    <= aux_ldo3_levels_d;
		end
	end

	// ************************************************************
	// Read answer flops
	// ************************************************************
	// Kept apart from storage so a read never disturbs a register
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			rdata_q  <= rvs_pkg::UNMAPPED_READ;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// ************************************************************
	// Sleep pin filters
	// ************************************************************
	wire logic [rvs_pkg::NUM_PINS-1:0] pin_lvl;

	// One filter per pin; each drives only its own bit
	for (genvar p = 0; p < rvs_pkg::NUM_PINS; p++) begin : g_pin
		rvs_pin_filter #(
			.SYNC_RST(rvs_pkg::PIN_SYNC_RST)
		) i_rvs_pin_filter (
			.i_clock(i_clock),
			.i_rst  (i_rst),
			.i_pin  (i_sleep_pin_n[p]),
			.o_level(pin_lvl[p])
		);
	end

	// ************************************************************
	// Level selection towards the regulators
	// ************************************************************
	logic [rvs_pkg::NUM_RAILS-1:0] sleep_q;
	logic [rvs_pkg::NUM_RAILS-1:0] sleep_d;
	rvs_pkg::rvs_levels_t          levels_q;
	rvs_pkg::rvs_levels_t          levels_d;

	// Sleep means enabled and the assigned pin low
	always_comb begin
		for (int r = 0; r < rvs_pkg::NUM_RAILS; r++) begin
			sleep_d[r] = i_sleep_en[r]
				& ~pin_lvl[i_sleep_pin_sel[r]];
		end
	end

	// Cleared in reset, so no rail starts out in sleep
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			sleep_q <= '0;
		end else begin
			sleep_q <= sleep_d;
		end
	end

	// ************************************************************
	// Applied codes
	// ************************************************************

	// Uses sleep_d so the level and flag change together
	always_comb begin
		levels_d.rail_five_sleep_code = rail5_sleep_level_q[
			rvs_pkg::CODE7_MSB:rvs_pkg::CODE7_LSB];
		levels_d.rail_six_code = sleep_d[rvs_pkg::RAIL6_IDX]
			? rail6_sleep_level_q[
				rvs_pkg::CODE7_MSB:rvs_pkg::CODE7_LSB]
			: rail6_normal_level_q[
				rvs_pkg::CODE7_MSB:rvs_pkg::CODE7_LSB];
		levels_d.rail_six_passive_fall =
			rail6_normal_level_q[rvs_pkg::FALL_BIT];
		levels_d.aux_two_code = sleep_d[rvs_pkg::AUX2_IDX]
			? aux_ldo2_levels_q[
				rvs_pkg::AUX_SLEEP_MSB:rvs_pkg::AUX_SLEEP_LSB]
			: aux_ldo2_levels_q[
				rvs_pkg::AUX_NORMAL_MSB:rvs_pkg::AUX_NORMAL_LSB];
		levels_d.aux_three_code = sleep_d[rvs_pkg::AUX3_IDX]
			? aux_ldo3_levels_q[
				rvs_pkg::AUX_SLEEP_MSB:rvs_pkg::AUX_SLEEP_LSB]
			: aux_ldo3_levels_q[
				rvs_pkg::AUX_NORMAL_MSB:rvs_pkg::AUX_NORMAL_LSB];
	end

	// Registered so every output comes from a flop
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			levels_q <= '0;
		end else begin
			levels_q <= levels_d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// Straight from the flops above, no logic after them
	assign o_rdata    = rdata_q;
	assign o_rvalid   = rvalid_q;
	assign o_levels   = levels_q;
	assign o_in_sleep = sleep_q;

endmodule : rvs_regs

`default_nettype wire

// ==== shared/rvs_pkg.sv ====
// Package for the rail voltage select register bank
package rvs_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] RAIL5_SLEEP_OFS = 8'h97;
	localparam logic [7:0] RAIL6_NORMAL_OFS = 8'h98;
	localparam logic [7:0] RAIL6_SLEEP_OFS = 8'h99;
	localparam logic [7:0] AUX2_LEVELS_OFS = 8'h9a;
	localparam logic [7:0] AUX3_LEVELS_OFS = 8'h9b;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CODE7_MSB = 7;
	localparam int CODE7_LSB = 1;
	localparam int FALL_BIT = 0;
	localparam int AUX_SLEEP_MSB = 7;
	localparam int AUX_SLEEP_LSB = 4;
	localparam int AUX_NORMAL_MSB = 3;
	localparam int AUX_NORMAL_LSB = 0;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam logic [7:0] CONV_SLEEP_WMASK = 8'hfe;

	// ************************************************************
	// Rail indices for sleep control vectors
	// ************************************************************
	localparam int RAIL5_IDX = 0;
	localparam int RAIL6_IDX = 1;
	localparam int AUX2_IDX = 2;
	localparam int AUX3_IDX = 3;
	localparam int NUM_RAILS = 4;
	localparam int NUM_PINS = 2;
	localparam int NUM_VARIANTS = 4;

	// ************************************************************
	// Factory defaults, one entry per part variant
	// ************************************************************
	localparam logic [7:0] RAIL5_SLEEP_RST [NUM_VARIANTS] =
		'{8'h70, 8'he8, 8'h40, 8'he8};
	localparam logic [7:0] RAIL6_NORMAL_RST [NUM_VARIANTS] =
		'{8'hbe, 8'hdc, 8'h70, 8'h58};
	localparam logic [7:0] RAIL6_SLEEP_RST [NUM_VARIANTS] =
		'{8'hbe, 8'h8c, 8'h70, 8'h4c};
	localparam logic [7:0] AUX2_LEVELS_RST [NUM_VARIANTS] =
		'{8'hff, 8'haa, 8'haa, 8'h00};
	localparam logic [7:0] AUX3_LEVELS_RST [NUM_VARIANTS] =
		'{8'haa, 8'haa, 8'haa, 8'h00};
	localparam logic [2:0] PIN_SYNC_RST = 3'h7;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rvs_req_t;

	typedef struct packed {
		logic [6:0] rail_five_sleep_code;
		logic [6:0] rail_six_code;
		logic       rail_six_passive_fall;
		logic [3:0] aux_two_code;
		logic [3:0] aux_three_code;
	} rvs_levels_t;

endpackage : rvs_pkg

// ==== test/rvs_regs_asserts.sv ====
// Assertion checker for the rail voltage select register bank
`timescale 1ns/1ps
`default_nettype none
module rvs_regs_asserts (
	input wire logic                          i_clock,
	input wire logic                          i_rst,
	input wire rvs_pkg::rvs_req_t             i_req,
	input wire logic [rvs_pkg::NUM_RAILS-1:0] i_sleep_en,
	input wire logic [7:0]                    o_rdata,
	input wire logic                          o_rvalid,
	input wire rvs_pkg::rvs_levels_t          o_levels,
	input wire logic [rvs_pkg::NUM_RAILS-1:0] o_in_sleep
);
	// One clock domain, so one clocking and one reset for all
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	AST_READ_ANSWER: assert property (i_req.rd |=> o_rvalid)
		else $error("read not answered");
	AST_NO_STRAY: assert property (!i_req.rd |=> !o_rvalid)
		else $error("answer without read");
	AST_R5_LSB: assert property (i_req.rd && i_req.addr == 8'h97
		|=> o_rdata[0] == 1'b0) else $error("reserved bit read high");
	AST_R6S_LSB: assert property (i_req.rd && i_req.addr == 8'h99
		|=> o_rdata[0] == 1'b0) else $error("reserved bit read high");
	AST_UNMAPPED: assert property (i_req.rd &&
		(i_req.addr < 8'h97 || i_req.addr > 8'h9b) |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_R5_CODE: assert property (i_req.wr && i_req.addr == 8'h97
		|-> ##2 o_levels.rail_five_sleep_code == $past(i_req.wdata[7:1], 2))
		else $error("rail five sleep code not applied");
	AST_FALL: assert property (i_req.wr && i_req.addr == 8'h98
		|-> ##2 o_levels.rail_six_passive_fall == $past(i_req.wdata[0], 2))
		else $error("fall select not applied");
	AST_SLEEP_OFF: assert property (i_sleep_en == 4'h0
		|=> o_in_sleep == 4'h0) else $error("sleep without enable");
endmodule : rvs_regs_asserts
bind rvs_regs rvs_regs_asserts i_rvs_regs_asserts (.i_clock, .i_rst, .i_req,
	.i_sleep_en, .o_rdata, .o_rvalid, .o_levels, .o_in_sleep);
`default_nettype wire

// ==== test/rvs_regs_tb.sv ====
// Self-checking bench for the rail voltage select register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
	$display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module rvs_regs_tb;
	logic                 i_clock = 1'b0;
	logic                 i_rst = 1'b1;
	rvs_pkg::rvs_req_t    i_req = '0;
	logic [1:0]           pin_n = 2'h3;
	logic [3:0]           en = 4'h0;
	logic [3:0]           sel = 4'h0;
	logic [7:0]           o_rdata;
	logic                 o_rvalid;
	rvs_pkg::rvs_levels_t o_levels;
	logic [3:0]           o_in_sleep;
	int                   errors = 0;
	int                   checked = 0;

	// Free running 100 MHz clock
	always #5 i_clock = ~i_clock;

	rvs_regs #(.PART_VARIANT(0)) i_rvs_regs (.i_clock(i_clock),
		.i_rst(i_rst), .i_req(i_req), .i_sleep_pin_n(pin_n),
		.i_sleep_en(en), .i_sleep_pin_sel(sel), .o_rdata(o_rdata),
		.o_rvalid(o_rvalid), .o_levels(o_levels), .o_in_sleep(o_in_sleep));

	// ************************************************************
	// Bus and level helpers
	// ************************************************************
	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_req <= '{1'b1, 1'b0, a, d};
		@(posedge i_clock);
		i_req <= '0;
	endtask : bus_wr

	// Answer lands on the same edge that takes the strobe
	task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clock);
		i_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge i_clock);
		i_req <= '0;
		#1;
		`CHK(o_rvalid, 1'b1)
		`CHK(o_rdata, e)
	endtask : bus_rd

	// Six edges cover the three flop sync, filter and output stage
	task automatic chk_lv(input logic [6:0] r6, input logic [3:0] a2,
		input logic [3:0] a3, input logic [3:0] sl);
		repeat (6) @(posedge i_clock);
		#1;
		`CHK(o_levels.rail_six_code, r6)
		`CHK(o_levels.aux_two_code, a2)
		`CHK(o_levels.aux_three_code, a3)
		`CHK(o_in_sleep, sl)
	endtask : chk_lv

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_defaults;
		bus_rd(8'h97, rvs_pkg::RAIL5_SLEEP_RST[0]);
		bus_rd(8'h98, rvs_pkg::RAIL6_NORMAL_RST[0]);
		bus_rd(8'h99, rvs_pkg::RAIL6_SLEEP_RST[0]);
		bus_rd(8'h9a, rvs_pkg::AUX2_LEVELS_RST[0]);
		bus_rd(8'h9b, rvs_pkg::AUX3_LEVELS_RST[0]);
		chk_lv(7'h5f, 4'hf, 4'ha, 4'h0);
		`CHK(o_levels.rail_five_sleep_code, 7'h38)
	endtask : t_defaults

	// All ones everywhere, including both unmapped neighbours
	task automatic t_write_all;
		logic [7:0] a;
		logic [7:0] e;
		for (a = 8'h96; a <= 8'h9c; a++) begin
			bus_wr(a, 8'hff);
		end
		for (a = 8'h96; a <= 8'h9c; a++) begin
			e = (a < 8'h97 || a > 8'h9b) ? 8'h00 : 8'hff;
			e = (a == 8'h97 || a == 8'h99) ? 8'hfe : e;
			bus_rd(a, e);
		end
		`CHK(o_levels.rail_five_sleep_code, 7'h7f)
		`CHK(o_levels.rail_six_passive_fall, 1'b1)
	endtask : t_write_all

	// Mid-run reset brings the factory set back; then one edge with
	// both strobes, where the read must still see the old contents
	task automatic t_reset;
		@(posedge i_clock);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		#1;
		`CHK(o_levels, '0)
		`CHK(o_rvalid, 1'b0)
		bus_rd(8'h97, rvs_pkg::RAIL5_SLEEP_RST[0]);
		bus_rd(8'h9b, rvs_pkg::AUX3_LEVELS_RST[0]);
		chk_lv(7'h5f, 4'hf, 4'ha, 4'h0);
		@(posedge i_clock);
		i_req <= '{1'b1, 1'b1, 8'h98, 8'h00};
		@(posedge i_clock);
		i_req <= '0;
		#1;
		`CHK(o_rdata, rvs_pkg::RAIL6_NORMAL_RST[0])
		bus_rd(8'h98, 8'h00);
	endtask : t_reset

	// Rail six and aux three follow pin one, the others pin zero
	task automatic t_sleep;
		bus_wr(8'h98, 8'h54);
		bus_wr(8'h99, 8'h34);
		bus_wr(8'h9a, 8'h3c);
		bus_wr(8'h9b, 8'h96);
		@(posedge i_clock);
		en <= 4'hf;
		sel <= 4'ha;
		pin_n <= 2'b10;
		chk_lv(7'h2a, 4'h3, 4'h6, 4'h5);
		`CHK(o_levels.rail_six_passive_fall, 1'b0)
		@(posedge i_clock);
		pin_n <= 2'b00;
		chk_lv(7'h1a, 4'h3, 4'h9, 4'hf);
		@(posedge i_clock);
		en <= 4'h0;
		chk_lv(7'h2a, 4'hc, 4'h6, 4'h0);
	endtask : t_sleep

	task automatic report_and_stop;
		if (errors == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop

	// Main sequence after five cycles of reset
	initial begin
		repeat (5) @(posedge i_clock);
		i_rst <= 1'b0;
		t_defaults();
		t_write_all();
		t_reset();
		t_sleep();
		report_and_stop();
	end

	// Whole run is under a hundred cycles; this cuts a hang
	initial begin
		#50000;
		errors++;
		report_and_stop();
	end
endmodule : rvs_regs_tb
`default_nettype wire
